// [src/stp_consts.vh]
// Constants of the test serial port: register map, fields, key values and frame shape
`ifndef STP_CONSTS_VH
`define STP_CONSTS_VH

// ==================================================
// Register byte addresses
`define STP_ADR_KEY0 32'hFFFF0880
`define STP_ADR_CTRL 32'hFFFF0884
`define STP_ADR_KEY1 32'hFFFF0888
`define STP_ADR_DAT0 32'hFFFF088C
`define STP_ADR_DAT1 32'hFFFF0890
`define STP_ADR_DAT2 32'hFFFF0894

// ==================================================
// Unlock key values
`define STP_KEY0_VAL 16'h0007
`define STP_KEY1_VAL 16'h00B9

// ==================================================
// Control register fields and reset values
`define STP_CTL_EN 0
`define STP_CTL_RST 1
`define STP_CTL_CNT 4:2
`define STP_CTL_STATE 8:5
`define STP_CTL_RSVD 15:9
`define STP_CTL_RESET 16'h0000
`define STP_DAT_RESET 16'h0000
`define STP_LO_BYTE 7:0
`define STP_HI_BYTE 15:8

// ==================================================
// Byte counts and frame shape
`define STP_CNT_MAX 3'h5
`define STP_FRAME_BITS 4'hC
`define STP_STOP_BITS 2'h3
`define STP_START_BIT 1'h0
`define STP_IDLE_LEVEL 1'h1

`endif

// [src/stp_frame_tx.v]
// Frame serialiser of the test serial port: one byte into a twelve-bit frame on the pin
`timescale 1ns/1ps
`include "stp_consts.vh"

module stp_frame_tx (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Frame request
  input wire start,
  input wire abort,
  input wire [7:0] byte_in,
  // Bit timing from the baud source timer overflow
  input wire baud_tick,
  // Status and serial line
  output reg busy_ff,
  output reg done_ff,
  output reg line_ff
);

  // ==================================================
  // Frame shift register and bit counter
  reg [11:0] shift_ff;
  reg [3:0] cnt_ff;

  // Load a frame, then move one bit per timer overflow, LSB first
  always @(posedge clk) begin
    if (!rst_n || abort) begin
      shift_ff <= 12'hFFF;
      cnt_ff <= 4'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      line_ff <= `STP_IDLE_LEVEL;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        // Stop bits, even parity, data, start bit
        shift_ff <= {`STP_STOP_BITS, ^byte_in, byte_in, `STP_START_BIT};
        cnt_ff <= 4'h0;
        busy_ff <= 1'b1;
      end else if (busy_ff && baud_tick) begin
        if (cnt_ff == `STP_FRAME_BITS) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          line_ff <= `STP_IDLE_LEVEL;
        end else begin
          line_ff <= shift_ff[0];
          shift_ff <= {`STP_IDLE_LEVEL, shift_ff[11:1]};
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end

endmodule

// [src/stp_key_guard.v]
// Two-key guard that lets a control write through only inside the full unlock sequence
`timescale 1ns/1ps
`include "stp_consts.vh"

module stp_key_guard (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Decoded bus writes
  input wire wr_any,
  input wire wr_key0,
  input wire wr_ctrl,
  input wire wr_key1,
  input wire [15:0] wdata,
  // Committed control value
  output reg commit_ff,
  output reg [15:0] value_ff
);

  // ==================================================
  // Sequence states
  localparam [2:0] G_IDLE = 3'b001;
  localparam [2:0] G_ARMED = 3'b010;
  localparam [2:0] G_HELD = 3'b100;

  reg [2:0] st_ff;
  wire key0_ok;

  assign key0_ok = wr_key0 && (wdata == `STP_KEY0_VAL);

  // Any write that is not the next step of the sequence breaks it
  always @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= G_IDLE;
      commit_ff <= 1'b0;
      value_ff <= `STP_CTL_RESET;
    end else begin
      commit_ff <= 1'b0;
      if (wr_any) begin
        case (st_ff)
          G_ARMED: begin
            if (wr_ctrl) begin
              value_ff <= wdata;
              st_ff <= G_HELD;
            end else begin
              st_ff <= key0_ok ? G_ARMED : G_IDLE;
            end
          end
          G_HELD: begin
            // Only the right second key releases the held value
            if (wr_key1 && (wdata == `STP_KEY1_VAL)) begin
              commit_ff <= 1'b1;
            end
            st_ff <= key0_ok ? G_ARMED : G_IDLE;
          end
          default: begin
            st_ff <= key0_ok ? G_ARMED : G_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// [src/stp_port.v]
// Transmit-only test serial port with Wishbone registers and a single output pin
//
// Function
// - Sends one to six bytes, twelve-bit frames.
// - Frame: start, eight data, parity, two stops.
// - Bit time set by external timer overflow.
// - Control write ignored without correct first key.
// - Held control write dropped without second key.
// - Bytes sent low byte first, three registers.
// - State field nonzero while a transmission runs.
// - Count codes zero to five select bytes.
// - Reset bit returns port to zeroed state.
// - Bit zero enables, clearing it disables port.
// - Start only after selected bytes are loaded.
// - Control readback differs while sending, then returns.
`timescale 1ns/1ps
`include "stp_consts.vh"

module stp_port (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Overflow pulse of the baud source timer
  input wire baud_tick,
  // Serial test pin
  output wire test_pin
);

  // ==================================================
  // Sequencer states
  localparam [2:0] SQ_IDLE = 3'b001;
  localparam [2:0] SQ_ISSUE = 3'b010;
  localparam [2:0] SQ_WAIT = 3'b100;

  // ==================================================
  // Declarations
  reg ack_ff;
  wire req;
  wire wr_now;
  wire rd_now;
  wire [15:0] wmask;
  wire [15:0] wdata;
  wire hit_key0;
  wire hit_ctrl;
  wire hit_key1;
  wire [2:0] hit_dat;
  wire hit_any;

  reg en_ff;
  reg [2:0] cnt_ff;
  wire commit;
  wire [15:0] commit_val;
  wire soft_rst;
  wire turn_off;
  wire abort;

  reg [15:0] dat_ff [0:2];
  reg [2:0] loaded_ff;
  wire [2:0] need;
  wire all_loaded;
  wire [2:0] last_idx;

  reg [2:0] sq_ff;
  reg [2:0] idx_ff;
  reg [7:0] cur_byte;
  wire seq_busy;
  wire finish;
  wire [3:0] state_field;
  wire [15:0] ctrl_rd;
  reg [15:0] rd_mux;

  wire fr_busy;
  wire fr_done;
  wire fr_line;

  // ==================================================
  // Wishbone handshake: ack one cycle after the request, dropped the next
  assign req = wb_cyc_i && wb_stb_i;
  assign wb_ack_o = ack_ff;
  assign wr_now = req && wb_we_i && ack_ff;
  assign rd_now = req && !wb_we_i && !ack_ff;

  // Acknowledge every access, mapped or not
  always @(posedge clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  // Byte lanes 0 and 1 carry the sixteen-bit registers
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata = wb_dat_i[15:0] & wmask;

  // Address decode
  assign hit_key0 = (wb_adr_i == `STP_ADR_KEY0);
  assign hit_ctrl = (wb_adr_i == `STP_ADR_CTRL);
  assign hit_key1 = (wb_adr_i == `STP_ADR_KEY1);
  assign hit_dat[0] = (wb_adr_i == `STP_ADR_DAT0);
  assign hit_dat[1] = (wb_adr_i == `STP_ADR_DAT1);
  assign hit_dat[2] = (wb_adr_i == `STP_ADR_DAT2);
  assign hit_any = hit_key0 || hit_ctrl || hit_key1 || (|hit_dat);

  // ==================================================
  // Protected control write sequence
  stp_key_guard u_guard (
    .clk(clk),
    .rst_n(rst_n),
    .wr_any(wr_now),
    .wr_key0(hit_key0),
    .wr_ctrl(hit_ctrl),
    .wr_key1(hit_key1),
    .wdata(wdata),
    .commit_ff(commit),
    .value_ff(commit_val)
  );

  // Effects of a committed control value
  assign soft_rst = commit && commit_val[`STP_CTL_RST];
  assign turn_off = commit && !commit_val[`STP_CTL_EN];
  assign abort = soft_rst || turn_off;

  // ==================================================
  // Control register: enable and byte count
  always @(posedge clk) begin
    if (!rst_n) begin
      en_ff <= 1'b0;
      cnt_ff <= 3'h0;
    end else if (soft_rst) begin
      en_ff <= 1'b0;
      cnt_ff <= 3'h0;
    end else if (commit) begin
      en_ff <= commit_val[`STP_CTL_EN];
      cnt_ff <= commit_val[`STP_CTL_CNT];
    end
  end

  // Codes above six bytes are held to six
  assign last_idx = (cnt_ff > `STP_CNT_MAX) ? `STP_CNT_MAX : cnt_ff;

  // ==================================================
  // Sequencer status
  assign seq_busy = !sq_ff[0];
  assign finish = sq_ff[2] && fr_done && (idx_ff == last_idx);

  // ==================================================
  // Data registers and their load flags, one per register
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_dat
      // Register k is needed when the last byte lies in or beyond it
      assign need[k] = ({1'b0, last_idx[2:1]} >= k);

      // Byte-lane write of the data word
      always @(posedge clk) begin
        if (!rst_n || soft_rst) begin
          dat_ff[k] <= `STP_DAT_RESET;
        end else if (wr_now && hit_dat[k]) begin
          dat_ff[k] <= (dat_ff[k] & ~wmask) | wdata;
        end
      end

      // A fresh control write or a finished transfer asks for new data
      always @(posedge clk) begin
        if (!rst_n || soft_rst || commit) begin
          loaded_ff[k] <= 1'b0;
        end else if (wr_now && hit_dat[k]) begin
          loaded_ff[k] <= 1'b1;
        end else if (finish) begin
          loaded_ff[k] <= 1'b0;
        end
      end
    end
  endgenerate

  assign all_loaded = &(loaded_ff | ~need);

  // ==================================================
  // Byte sequencer: issue frames one after another
  always @(posedge clk) begin
    if (!rst_n || abort) begin
      sq_ff <= SQ_IDLE;
      idx_ff <= 3'h0;
    end else begin
      case (sq_ff)
        SQ_IDLE: begin
          if (en_ff && all_loaded) begin
            sq_ff <= SQ_ISSUE;
            idx_ff <= 3'h0;
          end
        end
        SQ_ISSUE: begin
          sq_ff <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (fr_done) begin
            if (idx_ff == last_idx) begin
              sq_ff <= SQ_IDLE;
              idx_ff <= 3'h0;
            end else begin
              sq_ff <= SQ_ISSUE;
              idx_ff <= idx_ff + 3'h1;
            end
          end
        end
        default: begin
          sq_ff <= SQ_IDLE;
          idx_ff <= 3'h0;
        end
      endcase
    end
  end

  // Pick the byte: even index low half, odd index high half
  always @* begin
    case (idx_ff)
      3'h0: cur_byte = dat_ff[0][`STP_LO_BYTE];
      3'h1: cur_byte = dat_ff[0][`STP_HI_BYTE];
      3'h2: cur_byte = dat_ff[1][`STP_LO_BYTE];
      3'h3: cur_byte = dat_ff[1][`STP_HI_BYTE];
      3'h4: cur_byte = dat_ff[2][`STP_LO_BYTE];
      3'h5: cur_byte = dat_ff[2][`STP_HI_BYTE];
      default: cur_byte = 8'h00;
    endcase
  end

  // ==================================================
  // Frame serialiser
  stp_frame_tx u_frame (
    .clk(clk),
    .rst_n(rst_n),
    .start(sq_ff[1]),
    .abort(abort),
    .byte_in(cur_byte),
    .baud_tick(baud_tick),
    .busy_ff(fr_busy),
    .done_ff(fr_done),
    .line_ff(fr_line)
  );

  assign test_pin = fr_line;

  // ==================================================
  // Control readback: state shows the byte number in flight
  assign state_field = seq_busy ? ({1'b0, idx_ff} + 4'h1) : 4'h0;

  // Reserved and reset bits read as zero
  assign ctrl_rd = {7'h00, state_field, cnt_ff, 1'b0, en_ff};

  // Read multiplexer; keys and unmapped addresses read zero
  always @* begin
    rd_mux = 16'h0000;
    if (hit_ctrl) begin
      rd_mux = ctrl_rd;
    end else if (hit_dat[0]) begin
      rd_mux = dat_ff[0];
    end else if (hit_dat[1]) begin
      rd_mux = dat_ff[1];
    end else if (hit_dat[2]) begin
      rd_mux = dat_ff[2];
    end
  end

  // Read data is caught in the cycle before ack and held while ack is high
  always @(posedge clk) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd_now && hit_any) begin
      wb_dat_o <= {16'h0000, rd_mux};
    end else if (rd_now) begin
      wb_dat_o <= 32'h00000000;
    end
  end

endmodule

// [tb/stp_port_props.sv]
// Checker of bus answers and pin timing of the test serial port
`timescale 1ns/1ps
module stp_port_props (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Timer and pin
  input wire baud_tick,
  input wire test_pin
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==================================================
  // Bus steps
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  chk_ack_once: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  chk_rd_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read lanes not zero");
  chk_key_read: assert property (s_rd(32'hFFFF0888) |-> wb_dat_o == 32'h00000000)
    else $error("key register read not zero");
  chk_ctl_rsvd: assert property (s_rd(32'hFFFF0884) |-> !wb_dat_o[1] && !wb_dat_o[15:9])
    else $error("control reserved or reset bits read set");
  chk_unmapped: assert property (s_rd(32'hFFFF0898) |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  // ==================================================
  // Pin steps
  chk_fall_tick: assert property ($fell(test_pin) |-> $past(baud_tick))
    else $error("pin fell away from a bit boundary");
  chk_rise_cause: assert property ($rose(test_pin) |->
    $past(baud_tick) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("pin rose with no tick or control write");
  chk_state_busy: assert property (s_rd(32'hFFFF0884) && !test_pin |-> wb_dat_o[8:5] != 4'h0)
    else $error("state field zero mid-frame");
endmodule
bind stp_port stp_port_props i_props (
  .clk(clk),
  .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .baud_tick(baud_tick),
  .test_pin(test_pin)
);

// [tb/stp_rx_model.sv]
// Baud timer and diagnostic receiver standing on the test pin
`timescale 1ns/1ps
module stp_rx_model (
  // Clock
  input wire clk,
  // Timer period less one
  input wire [3:0] tick_gap,
  output reg baud_tick,
  // Line and received bytes
  input wire test_pin,
  output reg rx_stb,
  output reg [7:0] rx_byte,
  output reg rx_bad
);
  reg [3:0] div_ff = 4'h0;
  reg [3:0] pos_ff = 4'h0;
  reg [10:0] sh_ff = 11'h000;
  initial baud_tick = 1'b0;
  initial rx_stb = 1'b0;
  // Free-running overflow pulse, period set by the bench
  always @(posedge clk) begin
    div_ff <= (div_ff >= tick_gap) ? 4'h0 : div_ff + 4'h1;
    baud_tick <= (div_ff >= tick_gap);
  end
  // At each tick take the bit that stood since the previous one
  always @(posedge clk) begin : smp
    reg [10:0] f;
    f = {test_pin, sh_ff[10:1]};
    rx_stb <= 1'b0;
    if (baud_tick && pos_ff == 4'h0) begin
      pos_ff <= test_pin ? 4'h0 : 4'h1;
    end else if (baud_tick) begin
      sh_ff <= f;
      pos_ff <= (pos_ff == 4'hB) ? 4'h0 : pos_ff + 4'h1;
      rx_stb <= (pos_ff == 4'hB);
      rx_byte <= f[7:0];
      rx_bad <= (^f[8:0]) | ~f[9] | ~f[10];
    end
  end
endmodule

// [tb/test_stp_port.sv]
// Self-checking bench of the test serial port
`timescale 1ns/1ps
`include "stp_consts.vh"
module test_stp_port;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [31:0] wb_adr_i = 32'h00000000;
  reg [3:0] wb_sel_i = 4'h3;
  reg [31:0] wb_dat_i = 32'h00000000;
  reg [3:0] tick_gap = 4'h3;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire baud_tick;
  wire test_pin;
  wire rx_stb;
  wire [7:0] rx_byte;
  wire rx_bad;
  reg [15:0] rq;
  reg [15:0] v;
  reg [15:0] dat [0:2];
  byte unsigned rxq[$];
  reg rx_cut = 1'b0;
  integer err_total = 0;
  integer samples_checked = 0;
  integer c;
  integer i;
  integer n;
  always #12.5 clk = ~clk;
  stp_port i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .baud_tick(baud_tick), .test_pin(test_pin));
  stp_rx_model i_rx (.clk(clk), .tick_gap(tick_gap), .baud_tick(baud_tick),
    .test_pin(test_pin), .rx_stb(rx_stb), .rx_byte(rx_byte), .rx_bad(rx_bad));
  // ==================================================
  // Checks and bus cycles
  task chk(input string nm, input [15:0] s, input [15:0] e);
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task finish_test;
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wb_go(input [31:0] a, input w, input [15:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    n = 0;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk);
      n = n + 1;
    end
    if (n == 50) chk("ack", 16'h0000, 16'h0001);
    rq = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task ctl_wr(input [15:0] k0, input [15:0] d, input [15:0] k1);
    wb_go(`STP_ADR_KEY0, 1'b1, k0);
    wb_go(`STP_ADR_CTRL, 1'b1, d);
    wb_go(k1 == 16'h0000 ? `STP_ADR_DAT0 : `STP_ADR_KEY1, 1'b1, k1);
  endtask
  // Idle readback: enable and count kept, state, reset bit and reserved bits zero
  function [15:0] exp_ctl(input [15:0] w);
    exp_ctl = {11'h000, w[4:2], 1'b0, w[0]};
  endfunction
  // Byte k in send order
  function [7:0] exp_byte(input integer k);
    exp_byte = k[0] ? dat[k / 2][15:8] : dat[k / 2][7:0];
  endfunction
  always @(posedge clk) begin
    // A frame cut short by a disable ends in idle ones, so its parity is meaningless
    if (rx_stb === 1'b1 && !rx_cut) begin
      rxq.push_back(rx_byte);
      chk("frame", {15'h0000, rx_bad}, 16'h0000);
    end
  end
  // ==================================================
  // Main sequence
  initial begin
    rq = 16'($urandom(32'hAD51));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("idle pin", {15'h0000, test_pin}, 16'h0001);
    for (i = 0; i < 7; i = i + 1) begin
      wb_go(`STP_ADR_KEY0 + 32'(4 * i), 1'b0, 16'h0000);
      chk("reset value", rq, 16'h0000);
    end
    ctl_wr(16'h0006, 16'h0005, `STP_KEY1_VAL);
    wb_go(`STP_ADR_CTRL, 1'b0, 16'h0000);
    chk("bad key0", rq, 16'h0000);
    ctl_wr(`STP_KEY0_VAL, 16'h0005, 16'h0000);
    wb_go(`STP_ADR_CTRL, 1'b0, 16'h0000);
    chk("no key1", rq, 16'h0000);
    for (c = 0; c < 7; c = c + 1) begin
      tick_gap <= 4'($urandom_range(6, 1));
      v = {11'h000, 3'(c % 6), 2'b01};
      ctl_wr(`STP_KEY0_VAL, v, `STP_KEY1_VAL);
      rxq.delete();
      repeat (40) @(posedge clk);
      wb_go(`STP_ADR_CTRL, 1'b0, 16'h0000);
      chk("wait data", rq, exp_ctl(v));
      for (i = 0; i <= (c % 6) / 2; i = i + 1) begin
        dat[i] = 16'($urandom);
        wb_go(`STP_ADR_DAT0 + 32'(4 * i), 1'b1, dat[i]);
      end
      repeat (3) @(posedge clk);
      wb_go(`STP_ADR_CTRL, 1'b0, 16'h0000);
      chk("busy", {15'h0000, rq[8:5] != 4'h0}, 16'h0001);
      if (c == 6) begin
        rx_cut <= 1'b1;
        ctl_wr(`STP_KEY0_VAL, 16'h0000, `STP_KEY1_VAL);
        wb_go(`STP_ADR_CTRL, 1'b0, 16'h0000);
        chk("disable", rq, 16'h0000);
        chk("pin off", {15'h0000, test_pin}, 16'h0001);
      end else begin
        n = 0;
        while (rq !== exp_ctl(v) && n < 500) begin
          wb_go(`STP_ADR_CTRL, 1'b0, 16'h0000);
          n = n + 1;
        end
        repeat (2) @(posedge clk);
        chk("done", rq, exp_ctl(v));
        chk("count", 16'(rxq.size()), 16'(c + 1));
        for (i = 0; i < rxq.size(); i = i + 1)
          chk("byte", {8'h00, rxq[i]}, {8'h00, exp_byte(i)});
      end
    end
    ctl_wr(`STP_KEY0_VAL, 16'h0002, `STP_KEY1_VAL);
    wb_go(`STP_ADR_CTRL, 1'b0, 16'h0000);
    chk("soft reset", rq, 16'h0000);
    wb_go(`STP_ADR_DAT0, 1'b0, 16'h0000);
    chk("soft reset data", rq, 16'h0000);
    // Low lane only: the high byte keeps its cleared value
    wb_sel_i <= 4'h1;
    wb_go(`STP_ADR_DAT0, 1'b1, 16'hABCD);
    wb_sel_i <= 4'h3;
    wb_go(`STP_ADR_DAT0, 1'b0, 16'h0000);
    chk("lane write", rq, 16'h00CD);
    finish_test;
  end
  // Hang guard
  initial begin
    #(25 * 60000);
    err_total = err_total + 1;
    finish_test;
  end
endmodule
